// file: irq_ctrl.sv
// pc compatible programmable interrupt controller
// Summary of operation
// R1: base port read returns request or in-service register, as last selected
// R2: in-service bit is one while its line is being serviced
// R3: base port write with bit 4 set is first init word, starts init
// R4: software sets edge mode, single mode, fourth word requested
// R5: odd port writes after first word go to vector then mode word
// R6: vector word bits 7-3 give vector bits 7-3, line number fills 2-0
// R7: outside init, odd port reads and writes mask; zero enables line
// R8: sources are clock, external pin, infrared, serial, keyboard and touch
// R9: command bits 7-5 decode eoi, rotate, set priority and no operation
// R10: supply fault raises nmi when running or in light sleep, else forces backup
// R11: external pin high wakes system and raises an interrupt
// R12: bit 4 clear selects read/poll word on bit 3, else eoi word
// R13: software selects normal eoi and processor mode, one vector byte
module irq_ctrl
    import irq_ctrl_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [7:0]                 io_addr,
    input  wire logic [7:0]                 io_wdata,
    input  wire logic                       io_wr,
    input  wire logic                       io_rd,
    output logic      [7:0]                 io_rdata,
    input  wire logic                       inta,
    output logic      [7:0]                 vector,
    output logic                            irq_out,
    input  wire logic                       rtc_irq,
    input  wire logic                       ext_irq_pin,
    input  wire logic                       ir_irq,
    input  wire logic                       uart_irq,
    input  wire logic                       kbd_touch_irq,
    input  wire logic                       supply_good_n,
    input  wire irq_ctrl_pkg::power_state_t power_state,
    output logic                            nmi_out,
    output logic                            backup_out,
    output logic                            wake_out
);
    import irq_ctrl_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    init_state_t  init_st,  next_init_st;
    logic [7:0]   mask,     next_mask;
    logic [7:0]   isr,      next_isr;
    logic [4:0]   vbase,    next_vbase;
    logic         sel_isr,  next_sel_isr;
    logic         poll,     next_poll;
    logic         aeoi,     next_aeoi;
    logic         rot_aeoi, next_rot_aeoi;
    logic [2:0]   lowest,   next_lowest;
    logic         sg_last,  next_sg_last;
    logic [7:0]   next_rdata;
    logic [7:0]   next_vector;
    logic         next_irq;
    logic         next_nmi;
    logic         next_backup;
    logic         next_wake;
    logic [7:0]   src;
    logic [7:0]   irr;
    logic [7:0]   clr;
    logic         wr_base;
    logic         wr_odd;
    logic         rd_base;
    logic [2:0]   op;
    logic [2:0]   best;
    logic         best_ok;
    logic [2:0]   svc;
    logic         svc_ok;
    logic [2:0]   idx;

    // ------------------------------------------------------------
    // sources
    // ------------------------------------------------------------
    always_comb begin
        src           = '0;
        src[SRC_RTC]  = rtc_irq; // R8
        src[SRC_EXT]  = ext_irq_pin; // R11
        src[SRC_IR]   = ir_irq;
        src[SRC_UART] = uart_irq;
        src[SRC_KBD]  = kbd_touch_irq;
    end

    edge_catch #(
        .N(LINES)
    ) u_edges (
        .clk     (clk),
        .rst_n   (rst_n),
        .level   (src),
        .clear   (clr),
        .pending (irr)
    );

    assign wr_base = io_wr && (io_addr == ADDR_BASE);
    assign wr_odd  = io_wr && (io_addr == ADDR_ODD);
    assign rd_base = io_rd && (io_addr == ADDR_BASE);
    assign op      = io_wdata[7:5];

    // ------------------------------------------------------------
    // priority resolve, rotating from lowest+1
    // ------------------------------------------------------------
    always_comb begin
        best    = '0;
        best_ok = 1'b0;
        svc     = '0;
        svc_ok  = 1'b0;
        idx     = '0;
        for (int k = LINES - 1; k >= 0; k--) begin
            idx = 3'(lowest + 3'(k) + 3'd1);
            if (irr[idx] && !mask[idx]) begin // R7
                best    = idx;
                best_ok = 1'b1;
            end
            if (isr[idx]) begin
                svc    = idx;
                svc_ok = 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // command and register logic
    // ------------------------------------------------------------
    always_comb begin
        next_init_st  = init_st;
        next_mask     = mask;
        next_isr      = isr;
        next_vbase    = vbase;
        next_sel_isr  = sel_isr;
        next_poll     = poll;
        next_aeoi     = aeoi;
        next_rot_aeoi = rot_aeoi;
        next_lowest   = lowest;
        next_vector   = vector;
        clr           = '0;
        if (wr_base && io_wdata[W1_SEL_BIT]) begin // R3
            next_init_st = INIT_W2;
            next_isr     = '0;
            next_mask    = '0;
            next_sel_isr = 1'b0;
            next_lowest  = 3'h7;
            clr          = '1;
        end else if (wr_base && io_wdata[CMD_SEL_BIT]) begin // R12
            if (io_wdata[RR_BIT])
                next_sel_isr = io_wdata[RIS_BIT]; // R1
            next_poll = io_wdata[POLL_BIT];
        end else if (wr_base) begin // R12
            case (op) // R9
                OP_NS_EOI, OP_ROT_NS_EOI: begin
                    if (svc_ok) begin
                        next_isr[svc] = 1'b0;
                        if (op == OP_ROT_NS_EOI)
                            next_lowest = svc;
                    end
                end
                OP_SP_EOI, OP_ROT_SP_EOI: begin
                    next_isr[io_wdata[2:0]] = 1'b0;
                    if (op == OP_ROT_SP_EOI)
                        next_lowest = io_wdata[2:0];
                end
                OP_SET_PRI:      next_lowest   = io_wdata[2:0];
                OP_ROT_AEOI_SET: next_rot_aeoi = 1'b1;
                OP_ROT_AEOI_CLR: next_rot_aeoi = 1'b0;
                OP_NOP:          next_lowest   = lowest;
                default:         next_lowest   = lowest;
            endcase
        end else if (wr_odd) begin
            case (init_st) // R5
                INIT_W2: begin
                    next_vbase   = io_wdata[7:3]; // R6
                    next_init_st = INIT_W4;
                end
                INIT_W4: begin
                    next_aeoi    = io_wdata[AEOI_BIT];
                    next_init_st = INIT_IDLE;
                end
                INIT_IDLE: next_mask = io_wdata; // R7
                default:   next_init_st = INIT_IDLE;
            endcase
        end
        // acknowledge: move best request into service unless aeoi is set
        if ((inta || (rd_base && poll)) && best_ok && init_st == INIT_IDLE) begin
            clr[best]   = 1'b1;
            next_vector = {vbase, best}; // R6
            if (aeoi) begin
                if (rot_aeoi)
                    next_lowest = best;
            end else begin
                next_isr[best] = 1'b1; // R2 R13
            end
        end
        if (rd_base && poll)
            next_poll = 1'b0;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_comb begin
        next_rdata = io_rdata;
        if (io_rd) begin
            if (io_addr == ADDR_ODD)
                next_rdata = mask; // R7
            else if (io_addr == ADDR_BASE && poll)
                next_rdata = {best_ok, 4'h0, best};
            else if (io_addr == ADDR_BASE)
                next_rdata = sel_isr ? isr : irr; // R1 R2
            else
                next_rdata = '0;
        end
        next_irq     = best_ok && (init_st == INIT_IDLE) &&
                       (!svc_ok || (best != svc && isr[best] == 1'b0));
        next_sg_last = supply_good_n;
        next_nmi     = 1'b0;
        next_backup  = 1'b0;
        if (supply_good_n && (power_state == PWR_RUN || power_state == PWR_LIGHT))
            next_nmi = !sg_last; // R10
        else if (supply_good_n)
            next_backup = 1'b1; // R10
        next_wake = ext_irq_pin && (power_state != PWR_RUN); // R11
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            init_st    <= INIT_IDLE;
            mask       <= MASK_RESET;
            isr        <= '0;
            vbase      <= VBASE_RESET;
            sel_isr    <= 1'b0;
            poll       <= 1'b0;
            aeoi       <= 1'b0;
            rot_aeoi   <= 1'b0;
            lowest     <= 3'h7;
            sg_last    <= 1'b0;
            io_rdata   <= '0;
            vector     <= '0;
            irq_out    <= 1'b0;
            nmi_out    <= 1'b0;
            backup_out <= 1'b0;
            wake_out   <= 1'b0;
        end else begin
            init_st    <= next_init_st;
            mask       <= next_mask;
            isr        <= next_isr;
            vbase      <= next_vbase;
            sel_isr    <= next_sel_isr;
            poll       <= next_poll;
            aeoi       <= next_aeoi;
            rot_aeoi   <= next_rot_aeoi;
            lowest     <= next_lowest;
            sg_last    <= next_sg_last;
            io_rdata   <= next_rdata;
            vector     <= next_vector;
            irq_out    <= next_irq;
            nmi_out    <= next_nmi;
            backup_out <= next_backup;
            wake_out   <= next_wake;
        end
    end
endmodule

// file: irq_ctrl_pkg.sv
// constants for the pc compatible interrupt controller
package irq_ctrl_pkg;
    localparam logic [7:0] ADDR_BASE    = 8'h20;
    localparam logic [7:0] ADDR_ODD     = 8'h21;
    localparam int         LINES        = 8;
    localparam int         W1_SEL_BIT   = 4;
    localparam int         W1_LTIM_BIT  = 3;
    localparam int         W1_SNGL_BIT  = 1;
    localparam int         W1_IC4_BIT   = 0;
    localparam int         CMD_SEL_BIT  = 3;
    localparam int         POLL_BIT     = 2;
    localparam int         RR_BIT       = 1;
    localparam int         RIS_BIT      = 0;
    localparam int         SMM_BIT      = 6;
    localparam int         ESMM_BIT     = 5;
    localparam int         AEOI_BIT     = 1;
    localparam logic [7:0] MASK_RESET   = 8'hFF;
    localparam logic [4:0] VBASE_RESET  = 5'h01;
    // source positions in the request register
    localparam int         SRC_KBD      = 0;
    localparam int         SRC_UART     = 1;
    localparam int         SRC_IR       = 2;
    localparam int         SRC_EXT      = 3;
    localparam int         SRC_RTC      = 4;
    // eoi / priority command codes in bits 7-5
    localparam logic [2:0] OP_NS_EOI    = 3'h1;
    localparam logic [2:0] OP_NOP       = 3'h2;
    localparam logic [2:0] OP_SP_EOI    = 3'h3;
    localparam logic [2:0] OP_ROT_AEOI_SET = 3'h4;
    localparam logic [2:0] OP_ROT_NS_EOI   = 3'h5;
    localparam logic [2:0] OP_SET_PRI   = 3'h6;
    localparam logic [2:0] OP_ROT_SP_EOI   = 3'h7;
    localparam logic [2:0] OP_ROT_AEOI_CLR = 3'h0;

    typedef enum logic [1:0] {
        INIT_IDLE = 2'b00,
        INIT_W2   = 2'b01,
        INIT_W4   = 2'b11
    } init_state_t;

    typedef enum logic [1:0] {
        PWR_RUN   = 2'b00,
        PWR_LIGHT = 2'b01,
        PWR_DEEP  = 2'b11,
        PWR_OFF   = 2'b10
    } power_state_t;
endpackage

// file: edge_catch.sv
// per-line rising edge detector and request latch
module edge_catch #(
    parameter int N = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [N-1:0] level,
    input  wire logic [N-1:0] clear,
    output logic      [N-1:0] pending
);
    logic [N-1:0] last;
    logic [N-1:0] next_last;
    logic [N-1:0] next_pending;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_line
            // set wins over clear
            always_comb begin
                next_last[i]    = level[i];
                next_pending[i] = (level[i] & ~last[i]) | (pending[i] & ~clear[i]);
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            last    <= '0;
            pending <= '0;
        end else begin
            last    <= next_last;
            pending <= next_pending;
        end
    end
endmodule

// file: irq_ctrl_props.sv
// assertion checker bound to the interrupt controller
module irq_ctrl_props
    import irq_ctrl_pkg::*;
(
    input wire logic                       clk,
    input wire logic                       rst_n,
    input wire logic [7:0]                 io_addr,
    input wire logic [7:0]                 io_wdata,
    input wire logic                       io_wr,
    input wire logic                       io_rd,
    input wire logic [7:0]                 io_rdata,
    input wire logic                       inta,
    input wire logic [7:0]                 vector,
    input wire logic                       irq_out,
    input wire logic                       ext_irq_pin,
    input wire logic                       supply_good_n,
    input wire irq_ctrl_pkg::power_state_t power_state,
    input wire logic                       nmi_out,
    input wire logic                       backup_out,
    input wire logic                       wake_out
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    logic awake;
    logic sel_wr;
    logic base_rd;
    logic poll_armed;
    assign awake   = (power_state == PWR_RUN) || (power_state == PWR_LIGHT);
    assign sel_wr  = io_wr && io_addr == ADDR_BASE && !io_wdata[W1_SEL_BIT] && io_wdata[CMD_SEL_BIT];
    assign base_rd = io_rd && io_addr == ADDR_BASE;
    // poll read acknowledges like inta, so the vector may move then
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n)
            poll_armed <= 1'b0;
        else if (sel_wr)
            poll_armed <= io_wdata[POLL_BIT];
        else if (base_rd)
            poll_armed <= 1'b0;
    end
    AST_RD_HOLD: assert property (!io_rd |=> $stable(io_rdata))
        else $error("read data moved without a read");
    AST_VEC_HOLD: assert property (!inta && !(poll_armed && base_rd) |=> $stable(vector))
        else $error("vector moved without acknowledge");
    AST_VEC_LINE: assert property (inta && irq_out |=> vector[2:0] < 3'h5)
        else $error("vector names an unused line");
    AST_INIT_QUIET: assert property (io_wr && io_addr == ADDR_BASE && io_wdata[W1_SEL_BIT]
        |=> ##1 !irq_out) else $error("request during init");
    AST_NMI: assert property ($rose(supply_good_n) && awake |=> nmi_out)
        else $error("no nmi on supply fault");
    AST_NMI_PULSE: assert property (nmi_out |=> !nmi_out)
        else $error("nmi longer than one cycle");
    AST_BACKUP: assert property (supply_good_n && !awake |=> backup_out)
        else $error("no backup while asleep");
    AST_WAKE: assert property (ext_irq_pin && power_state != PWR_RUN |=> wake_out)
        else $error("no wake from external pin");
    AST_NO_WAKE: assert property (!ext_irq_pin |=> !wake_out)
        else $error("wake without external pin");
    COV_NMI: cover property (nmi_out);
    COV_ACK: cover property (inta && irq_out);
    COV_BACKUP: cover property (backup_out);
    COV_POLL: cover property (poll_armed && base_rd);
endmodule
bind irq_ctrl irq_ctrl_props u_props (.clk(clk), .rst_n(rst_n), .io_addr(io_addr),
    .io_wdata(io_wdata), .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .inta(inta),
    .vector(vector), .irq_out(irq_out), .ext_irq_pin(ext_irq_pin),
    .supply_good_n(supply_good_n), .power_state(power_state), .nmi_out(nmi_out),
    .backup_out(backup_out), .wake_out(wake_out));

// file: host_model.sv
// host processor model driving the controller io bus
module host_model (
    input  wire logic       clk,
    output logic      [7:0] io_addr,
    output logic      [7:0] io_wdata,
    output logic            io_wr,
    output logic            io_rd,
    output logic            inta
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        io_addr = 8'h00;
        io_wdata = 8'h00;
        io_wr = 1'b0;
        io_rd = 1'b0;
        inta = 1'b0;
    end
    // released data shows the inverse
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        io_addr <= a;
        io_wdata <= d;
        io_wr <= 1'b1;
        @(posedge clk);
        io_wr <= 1'b0;
        io_wdata <= ~d;
    endtask
    task automatic rd(input logic [7:0] a);
        @(posedge clk);
        io_addr <= a;
        io_rd <= 1'b1;
        @(posedge clk);
        io_rd <= 1'b0;
    endtask
    task automatic ack();
        @(posedge clk);
        inta <= 1'b1;
        @(posedge clk);
        inta <= 1'b0;
    endtask
endmodule

// file: irq_ctrl_tb.sv
// self-checking testbench for the interrupt controller
module irq_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import irq_ctrl_pkg::*;
    logic         clk = 1'b0;
    logic         rst_n = 1'b0;
    logic [4:0]   src = 5'h00;
    logic         supply_good_n = 1'b0;
    power_state_t power_state = PWR_RUN;
    logic [7:0]   io_addr, io_wdata, io_rdata, vector, vb, m;
    logic         io_wr, io_rd, inta, irq_out, nmi_out, backup_out, wake_out;
    logic         rd_d = 1'b0;
    logic         ack_d = 1'b0;
    logic [7:0]   exp_q[$];
    logic [7:0]   eoi[5] = '{8'h20, 8'h61, 8'hA0, 8'hE3, 8'h20};
    logic [7:0]   cmd[4] = '{8'h40, 8'h80, 8'h00, 8'hC7};
    int           n_errors = 0;
    int           num_checks = 0;
    always #2 clk = ~clk;
    host_model host (.clk(clk), .io_addr(io_addr), .io_wdata(io_wdata), .io_wr(io_wr),
        .io_rd(io_rd), .inta(inta));
    irq_ctrl dut (.clk(clk), .rst_n(rst_n), .io_addr(io_addr), .io_wdata(io_wdata),
        .io_wr(io_wr), .io_rd(io_rd), .io_rdata(io_rdata), .inta(inta), .vector(vector),
        .irq_out(irq_out), .rtc_irq(src[4]), .ext_irq_pin(src[3]), .ir_irq(src[2]),
        .uart_irq(src[1]), .kbd_touch_irq(src[0]), .supply_good_n(supply_good_n),
        .power_state(power_state), .nmi_out(nmi_out), .backup_out(backup_out),
        .wake_out(wake_out));
    task automatic chk(input string what, input logic [7:0] e, input logic [7:0] g);
        num_checks++;
        if (g !== e) begin
            n_errors++;
            $display("ERROR %s expected %h seen %h", what, e, g);
        end
    endtask
    task automatic test_done();
        if (n_errors == 0 && num_checks > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic read_exp(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        host.rd(a);
    endtask
    // raise a line, take its vector, check and end its service
    task automatic serve(input int i);
        int k = 0;
        src[i] <= 1'b1;
        while (irq_out !== 1'b1 && k < 20) begin
            @(posedge clk);
            k++;
        end
        chk("irq_out", 8'h01, {7'h00, irq_out});
        exp_q.push_back({vb[7:3], 3'(i)});
        host.ack();
        src[i] <= 1'b0;
        read_exp(ADDR_BASE, 8'(1 << i));
        host.wr(ADDR_BASE, eoi[i]);
        read_exp(ADDR_BASE, 8'h00);
    endtask
    // ------------------------------
    // result watcher
    // ------------------------------
    always @(posedge clk) begin
        if (rd_d) chk("io_rdata", exp_q.pop_front(), io_rdata);
        if (ack_d) chk("vector", exp_q.pop_front(), vector);
        rd_d <= io_rd;
        ack_d <= inta;
    end
    initial begin
        #20000;
        n_errors++;
        test_done();
    end
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        void'($urandom(3408));
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        read_exp(ADDR_ODD, MASK_RESET);
        read_exp(8'h30, 8'h00);
        vb = 8'($urandom);
        host.wr(ADDR_BASE, 8'h13);
        host.wr(ADDR_ODD, vb);
        host.wr(ADDR_ODD, 8'h01);
        read_exp(ADDR_ODD, 8'h00);
        m = 8'($urandom);
        host.wr(ADDR_ODD, m);
        read_exp(ADDR_ODD, m);
        host.wr(ADDR_ODD, 8'hE0);
        foreach (cmd[c]) host.wr(ADDR_BASE, cmd[c]);
        host.wr(ADDR_BASE, 8'h0B);
        for (int i = 0; i < 5; i++) serve(i);
        // poll: a base read acknowledges the best line and returns it
        src[2] <= 1'b1;
        host.wr(ADDR_BASE, 8'h0C);
        read_exp(ADDR_BASE, 8'h82);
        src[2] <= 1'b0;
        host.wr(ADDR_BASE, 8'h62);
        chk("vector", {vb[7:3], 3'h2}, vector);
        host.wr(ADDR_ODD, 8'hFF);
        host.wr(ADDR_BASE, 8'h0A);
        src[3] <= 1'b1;
        repeat (4) @(posedge clk);
        chk("irq_out", 8'h00, {7'h00, irq_out});
        src[3] <= 1'b0;
        read_exp(ADDR_BASE, 8'h08);
        for (int p = 0; p < 4; p++) begin
            @(posedge clk);
            power_state <= power_state_t'(p[1:0]);
            supply_good_n <= 1'b1;
            src[3] <= 1'b1;
            @(posedge clk);
            #1;
            chk("nmi_out", 8'(p < 2), {7'h00, nmi_out});
            @(posedge clk);
            #1;
            chk("backup_out", 8'(p >= 2), {7'h00, backup_out});
            chk("wake_out", 8'(p != 0), {7'h00, wake_out});
            @(posedge clk);
            supply_good_n <= 1'b0;
            src[3] <= 1'b0;
            @(posedge clk);
        end
        repeat (4) @(posedge clk);
        test_done();
    end
endmodule
